// *** hdl/syt_timer_regs.sv ***
// System timer: AXI4-Lite registers, interval, watchdog and seconds timers
// Operation
// R1 - Ten word registers at offsets 0x00 to 0x24
// R2 - Control bit 0 one restarts watchdog
// R3 - Period preload; zero means 65536 slow cycles
// R4 - Watchdog preload; zero means 65536 times 128
// R5 - Reset-enable bit 16 makes overflow reset
// R6 - Bit 17 drives overflow output low 8 slow cycles
// R7 - Prescale sets slow periods per seconds increment
// R8 - Status bit 0: interval reached zero
// R9 - Status bit 1: watchdog reached zero
// R10 - Status bit 2: seconds counter incremented
// R11 - Status bit 3: seconds matched alarm
// R12 - Reset values: maximum periods, watchdog 0x00020000
// R13 - Interval auto-reloads; period write restarts it
// R14 - Watchdog on slow/128; restart resets divider
// R15 - Twenty-bit seconds counter, rolls over, compared
// R16 - Realtime write restarts prescaler, clears seconds
// R17 - Interrupt from masked flags; no lost events
// R18 - Slow clock synchronised before flags set
//
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
module syt_timer_regs #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  slow_clock,
  output var  logic                  timer_irq,
  output var  logic                  overflow_out_n,
  output var  logic                  watchdog_reset
);
  if (ADDR_WIDTH < 6 || ADDR_WIDTH > 32) begin : g_check
    $error("syt_timer_regs needs ADDR_WIDTH from 6 to 32");
  end

  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i])
        res[8*i +: 8] = new_val[8*i +: 8];
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [7:0] ofs);
    return (ofs[1:0] == 2'b00) && (ofs <= syt_pkg::OFS_SECONDS);
  endfunction

  // Software-visible state
  logic [15:0]            period_preload;
  logic [17:0]            watchdog_mode;
  logic [15:0]            seconds_prescale;
  logic [19:0]            alarm_value;
  logic [19:0]            seconds_count;
  logic [3:0]             irq_mask;
  syt_pkg::syt_flags_type flags;

  // Bus channel state
  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             aw_ofs_q;
  logic [31:0]            w_data_q;
  logic [3:0]             w_strb_q;

  // Slow clock pin synchroniser and qualified level
  logic                   slow_s1;
  logic                   slow_s2;
  logic                   slow_s3;
  logic                   slow_level;
  logic [3:0]             ovf_count;

  wire logic        slow_agree = (slow_s2 == slow_s3);
  wire logic        slow_tick  = slow_agree & slow_s3 & ~slow_level;

  // Write channel handshakes; address and data may come in either order
  wire logic        aw_take    = s_axi_awvalid & s_axi_awready;
  wire logic        w_take     = s_axi_wvalid & s_axi_wready;
  wire logic        have_aw    = aw_held | aw_take;
  wire logic        have_w     = w_held | w_take;
  wire logic        do_write   = have_aw & have_w;
  wire logic [7:0]  wr_ofs     = aw_take ? 8'(s_axi_awaddr) : aw_ofs_q;
  wire logic [31:0] wr_data    = w_take ? s_axi_wdata : w_data_q;
  wire logic [3:0]  wr_strb    = w_take ? s_axi_wstrb : w_strb_q;
  wire logic        next_aw_held = have_aw & ~do_write;
  wire logic        next_w_held  = have_w & ~do_write;
  wire logic        next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);

  wire logic        wr_control = do_write && wr_ofs == syt_pkg::OFS_CONTROL;
  wire logic        wr_period  = do_write && wr_ofs == syt_pkg::OFS_PERIOD;
  wire logic        wr_wdog    = do_write && wr_ofs == syt_pkg::OFS_WATCHDOG;
  wire logic        wr_rtime   = do_write && wr_ofs == syt_pkg::OFS_REALTIME;
  wire logic        wr_ien     = do_write && wr_ofs == syt_pkg::OFS_IRQ_ENABLE;
  wire logic        wr_idis    = do_write && wr_ofs == syt_pkg::OFS_IRQ_DISABL;
  wire logic        wr_alarm   = do_write && wr_ofs == syt_pkg::OFS_ALARM;
  wire logic [31:0] wr_merged_period =
    merge_strb({16'h0000, period_preload}, wr_data, wr_strb);
  wire logic [31:0] wr_merged_wdog =
    merge_strb({14'h0000, watchdog_mode}, wr_data, wr_strb);
  wire logic [31:0] wr_merged_rtime =
    merge_strb({16'h0000, seconds_prescale}, wr_data, wr_strb);
  wire logic [31:0] wr_merged_alarm =
    merge_strb({12'h000, alarm_value}, wr_data, wr_strb);

  // Restart only on a written one; a zero leaves the watchdog alone
  wire logic watchdog_restart =
    wr_control & wr_strb[0] & wr_data[syt_pkg::RESTART_BIT]; // [R2]

  // Read channel
  wire logic        ar_take     = s_axi_arvalid & s_axi_arready;
  wire logic [7:0]  rd_ofs      = 8'(s_axi_araddr);
  wire logic        next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire logic        rd_status   = ar_take && rd_ofs == syt_pkg::OFS_STATUS;
  wire logic [31:0] rd_value; // [R1]
  assign rd_value =
    (rd_ofs == syt_pkg::OFS_PERIOD)   ? {16'h0000, period_preload}   :
    (rd_ofs == syt_pkg::OFS_WATCHDOG) ? {14'h0000, watchdog_mode}    :
    (rd_ofs == syt_pkg::OFS_REALTIME) ? {16'h0000, seconds_prescale} :
    (rd_ofs == syt_pkg::OFS_STATUS)   ? {28'h0000000, flags}         :
    (rd_ofs == syt_pkg::OFS_IRQ_MASK) ? {28'h0000000, irq_mask}      :
    (rd_ofs == syt_pkg::OFS_ALARM)    ? {12'h000, alarm_value}       :
    (rd_ofs == syt_pkg::OFS_SECONDS)  ? {12'h000, seconds_count}     :
                                        32'h00000000;

  // A period or realtime write restarts its counter from the value being written, not
  // from the register, which only takes the new value at the same edge
  wire logic [15:0] period_load   =
    wr_period ? wr_merged_period[15:0] : period_preload;   // [R13]
  wire logic [15:0] prescale_load =
    wr_rtime ? wr_merged_rtime[15:0] : seconds_prescale;   // [R16]

  // Timer engines
  logic period_expire;
  logic wd_div_tick;
  logic wd_expire;
  logic prescale_expire;

  syt_down_counter #(
    .WIDTH       (16),
    .RESET_COUNT (syt_pkg::PERIOD_RESET)
  ) u_period (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (slow_tick),
    .restart (wr_period),                          // [R13]
    .preload (period_load),                        // [R3]
    .expire  (period_expire)
  );

  // Divider by 128 restarts together with the watchdog
  syt_down_counter #(
    .WIDTH       (syt_pkg::WD_DIV_WIDTH),
    .RESET_COUNT (syt_pkg::WD_DIV_PRELOAD)
  ) u_wd_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (slow_tick),
    .restart (watchdog_restart),                   // [R14]
    .preload (syt_pkg::WD_DIV_PRELOAD),
    .expire  (wd_div_tick)
  );

  // Mode writes leave the running watchdog count untouched
  syt_down_counter #(
    .WIDTH       (16),
    .RESET_COUNT (syt_pkg::WATCHDOG_RESET[15:0])
  ) u_watchdog (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (wd_div_tick),                        // [R14]
    .restart (watchdog_restart),                   // [R2]
    .preload (watchdog_mode[15:0]),                // [R4]
    .expire  (wd_expire)
  );

  syt_down_counter #(
    .WIDTH       (16),
    .RESET_COUNT (syt_pkg::REALTIME_RESET)
  ) u_prescale (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (slow_tick),
    .restart (wr_rtime),                           // [R16]
    .preload (prescale_load),                      // [R7]
    .expire  (prescale_expire)
  );

  wire logic [19:0] seconds_inc = seconds_count + 20'h00001; // [R15]
  wire logic        sec_step    = prescale_expire & ~wr_rtime;
  wire logic        alarm_hit   = sec_step && seconds_inc == alarm_value;

  wire syt_pkg::syt_flags_type flag_set = '{
    alarm:    alarm_hit,                           // [R11]
    tick:     sec_step,                            // [R10]
    watchdog: wd_expire,                           // [R9]
    period:   period_expire                        // [R8]
  };
  // A new event in the reading cycle survives the clear
  wire syt_pkg::syt_flags_type next_flags =
    (rd_status ? 4'h0 : flags) | flag_set;         // [R17]

  wire logic [3:0]  next_ovf_count =
    (wd_expire & watchdog_mode[syt_pkg::OVERFLOW_OUTPUT_ENABLE_BIT]) ? syt_pkg::OVF_OUT_CYCLES :
    (slow_tick && ovf_count != 4'h0) ? ovf_count - 4'h1 : ovf_count; // [R6]

  // Synchroniser: only the second stage reads the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_s1    <= 1'b0;
      slow_s2    <= 1'b0;
      slow_s3    <= 1'b0;
      slow_level <= 1'b0;
    end else begin
      slow_s1    <= slow_clock;                    // [R18]
      slow_s2    <= slow_s1;
      slow_s3    <= slow_s2;
      if (slow_agree)
        slow_level <= slow_s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_ofs_q      <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= syt_pkg::RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready  <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_take)
        aw_ofs_q <= 8'(s_axi_awaddr);
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
        s_axi_bresp <= is_mapped(wr_ofs) ? syt_pkg::RESP_OKAY
                                         : syt_pkg::RESP_SLVERR; // [R1]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= syt_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= is_mapped(rd_ofs) ? rd_value : 32'h00000000;
        s_axi_rresp <= is_mapped(rd_ofs) ? syt_pkg::RESP_OKAY
                                         : syt_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_preload   <= syt_pkg::PERIOD_RESET;   // [R12]
      watchdog_mode    <= syt_pkg::WATCHDOG_RESET; // [R12]
      seconds_prescale <= syt_pkg::REALTIME_RESET;
      alarm_value      <= syt_pkg::ALARM_RESET;
      irq_mask         <= syt_pkg::MASK_RESET;
    end else begin
      if (wr_period)
        period_preload <= wr_merged_period[15:0];  // [R3]
      if (wr_wdog)
        watchdog_mode <= wr_merged_wdog[17:0];     // [R4]
      if (wr_rtime)
        seconds_prescale <= wr_merged_rtime[15:0]; // [R7]
      if (wr_alarm)
        alarm_value <= wr_merged_alarm[19:0];
      if (wr_ien & wr_strb[0])
        irq_mask <= irq_mask | wr_data[3:0];
      else if (wr_idis & wr_strb[0])
        irq_mask <= irq_mask & ~wr_data[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seconds_count  <= 20'h00000;
      flags          <= '0;
      ovf_count      <= 4'h0;
      overflow_out_n <= 1'b1;
      watchdog_reset <= 1'b0;
      timer_irq      <= 1'b0;
    end else begin
      if (wr_rtime)
        seconds_count <= 20'h00000;                // [R16]
      else if (sec_step)
        seconds_count <= seconds_inc;              // [R15]
      flags          <= next_flags;
      ovf_count      <= next_ovf_count;
      overflow_out_n <= (next_ovf_count == 4'h0);  // [R6]
      watchdog_reset <= wd_expire & watchdog_mode[syt_pkg::OVERFLOW_RESET_ENABLE_BIT]; // [R5]
      timer_irq      <= |(next_flags & irq_mask);  // [R17]
    end
  end
endmodule // syt_timer_regs
`default_nettype wire

// *** hdl/syt_pkg.sv ***
// Package: register map, field layout and reset values of the system timer
`default_nettype none
package syt_pkg;
  localparam logic [31:0] BASE_ADDR      = 32'hFFFF8000;
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_PERIOD     = 8'h04;
  localparam logic [7:0]  OFS_WATCHDOG   = 8'h08;
  localparam logic [7:0]  OFS_REALTIME   = 8'h0C;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;
  localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0]  OFS_IRQ_DISABL = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h1C;
  localparam logic [7:0]  OFS_ALARM      = 8'h20;
  localparam logic [7:0]  OFS_SECONDS    = 8'h24;

  localparam int          RESTART_BIT    = 0;
  localparam int          OVERFLOW_RESET_ENABLE_BIT      = 16;
  localparam int          OVERFLOW_OUTPUT_ENABLE_BIT      = 17;
  localparam int          FLAG_PERIOD    = 0;
  localparam int          FLAG_WATCHDOG  = 1;
  localparam int          FLAG_TICK      = 2;
  localparam int          FLAG_ALARM     = 3;

  localparam logic [15:0] PERIOD_RESET   = 16'h0000;
  localparam logic [17:0] WATCHDOG_RESET = 18'h20000;
  localparam logic [15:0] REALTIME_RESET = 16'h8000;
  localparam logic [19:0] ALARM_RESET    = 20'h00000;
  localparam logic [3:0]  MASK_RESET     = 4'h0;

  localparam int          WD_DIV_WIDTH   = 7;
  localparam logic [6:0]  WD_DIV_PRELOAD = 7'h00;
  localparam logic [3:0]  OVF_OUT_CYCLES = 4'h8;

  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef struct packed {
    logic alarm;
    logic tick;
    logic watchdog;
    logic period;
  } syt_flags_type;
endpackage
`default_nettype wire

// *** hdl/syt_down_counter.sv ***
// Reloading down-counter: a preload of zero gives 2**WIDTH ticks
`default_nettype none
module syt_down_counter #(
  parameter int               WIDTH       = 16,
  parameter logic [WIDTH-1:0] RESET_COUNT = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             tick,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] preload,
  output var  logic             expire
);
  logic [WIDTH-1:0] count;
  wire              at_one = (count == WIDTH'(1));

  if (WIDTH < 2) begin : g_check
    $error("syt_down_counter needs WIDTH of at least 2");
  end

  // Decrement from zero wraps, so zero means the full range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count  <= RESET_COUNT;
      expire <= 1'b0;
    end else begin
      expire <= tick & at_one & ~restart;
      if (restart)
        count <= preload;
      else if (tick)
        count <= at_one ? preload : count - WIDTH'(1);
    end
  end
endmodule // syt_down_counter
`default_nettype wire

// *** tb/syt_timer_regs_monitor.sv ***
// Checker: bus handshake and timer output relations at the top ports
`default_nettype none
module syt_timer_regs_monitor #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic                  timer_irq,
  input wire logic                  overflow_out_n,
  input wire logic                  watchdog_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rd_ofs;
  // Offset of the read in flight, so data can be tied to its register
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_ofs <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_ofs <= s_axi_araddr[7:0];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RESET_IDLE: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && overflow_out_n && !watchdog_reset
    && !timer_irq) else $error("outputs not idle after reset");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr > 8'h24) |=> s_axi_rresp == syt_pkg::RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  AST_WO_ZERO: assert property (s_axi_rvalid
    && rd_ofs == syt_pkg::OFS_CONTROL |-> s_axi_rdata == 32'h0)
    else $error("control read not zero");
  AST_STATUS_BITS: assert property (s_axi_rvalid
    && rd_ofs == syt_pkg::OFS_STATUS |-> s_axi_rdata[31:4] == 28'h0)
    else $error("status upper bits set");
  AST_IRQ_OFF: assert property (s_axi_rvalid
    && rd_ofs == syt_pkg::OFS_IRQ_MASK && s_axi_rdata[3:0] == 4'h0
    |-> !timer_irq) else $error("irq with empty mask");
  AST_WDR_PULSE: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("reset request longer than one cycle");
  AST_OVF_WIDTH: assert property ($fell(overflow_out_n) |=>
    !overflow_out_n [*8]) else $error("overflow output too short");
endmodule // syt_timer_regs_monitor
bind syt_timer_regs syt_timer_regs_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_irq(timer_irq),
  .overflow_out_n(overflow_out_n), .watchdog_reset(watchdog_reset));
`default_nettype wire

// *** tb/syt_timer_regs_test.sv ***
// Testbench: register access, interval, seconds and watchdog scenarios
`default_nettype none
module syt_timer_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, slow_clock = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        timer_irq, ovf_n, wd_rst;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          err_count = 0, total_checks = 0, wdr_seen = 0, ovf_low = 0;
  always #20 aclk = ~aclk;
  syt_timer_regs #(.ADDR_WIDTH(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slow_clock(slow_clock),
    .timer_irq(timer_irq), .overflow_out_n(ovf_n), .watchdog_reset(wd_rst));
  always @(posedge aclk) begin
    if (wd_rst === 1'b1) wdr_seen++;
    if (ovf_n === 1'b0) ovf_low++;
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rsp = syt_pkg::RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    chk("bresp", {30'h0, rsp}, {30'h0, bresp});
    bready <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] exp, input logic [31:0] msk = '1,
                    input logic [1:0] rsp = syt_pkg::RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(nm, exp, rdata & msk);
    chk("rresp", {30'h0, rsp}, {30'h0, rresp});
  endtask
  // Slow ticks are driven exactly, so counts can be predicted edge by edge
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (5) @(posedge aclk);
      slow_clock <= 1'b1;
      repeat (5) @(posedge aclk);
      slow_clock <= 1'b0;
    end
    repeat (10) @(posedge aclk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end
  initial begin
    logic [7:0]  ofs [11];
    logic [31:0] rv [11];
    ofs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
            8'h20, 8'h24, 8'h28};
    rv = '{32'h0, 32'h0, 32'h00020000, 32'h00008000, 32'h0, 32'h0, 32'h0,
           32'h0, 32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wr(8'h24, 32'h5);
    for (int i = 0; i < 10; i++) rd("reset", ofs[i], rv[i]);
    rd("unmapped", ofs[10], 32'h0, '1, syt_pkg::RESP_SLVERR);
    wr(8'h2A, 32'h1, syt_pkg::RESP_SLVERR);
    $display("test reset values done");
    wr(syt_pkg::OFS_IRQ_ENABLE, 32'h1);
    rd("mask", syt_pkg::OFS_IRQ_MASK, 32'h1);
    wr(syt_pkg::OFS_PERIOD, 32'h3);
    ticks(2);
    wr(syt_pkg::OFS_PERIOD, 32'h3);
    ticks(2);
    rd("period early", syt_pkg::OFS_STATUS, 32'h0, 32'h1);
    ticks(1);
    chk("irq", 32'h1, {31'h0, timer_irq});
    rd("period", syt_pkg::OFS_STATUS, 32'h1, 32'h1);
    rd("period clr", syt_pkg::OFS_STATUS, 32'h0, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq clr", 32'h0, {31'h0, timer_irq});
    wr(syt_pkg::OFS_IRQ_DISABL, 32'h1);
    rd("mask off", syt_pkg::OFS_IRQ_MASK, 32'h0);
    $display("test interval done");
    wr(syt_pkg::OFS_REALTIME, 32'h2);
    wr(syt_pkg::OFS_ALARM, 32'h3);
    rd("alarm", syt_pkg::OFS_ALARM, 32'h3);
    ticks(7);
    rd("seconds", syt_pkg::OFS_SECONDS, 32'h3);
    rd("tick alarm", syt_pkg::OFS_STATUS, 32'hC, 32'hC);
    wr(syt_pkg::OFS_REALTIME, 32'h2);
    rd("seconds clr", syt_pkg::OFS_SECONDS, 32'h0);
    $display("test seconds done");
    wr(syt_pkg::OFS_WATCHDOG, 32'h00030001);
    wr(syt_pkg::OFS_CONTROL, 32'h1);
    ticks(120);
    // Neither of these may restart the count, so expiry stays near 128
    wr(syt_pkg::OFS_CONTROL, 32'h0);
    wr(syt_pkg::OFS_WATCHDOG, 32'h00030001);
    chk("wd early", 32'h0, wdr_seen);
    ticks(24);
    chk("wd reset", 32'h1, wdr_seen);
    chk("ovf low", 32'h1, {31'h0, ovf_low >= 64});
    chk("ovf end", 32'h1, {31'h0, ovf_n});
    rd("wd flag", syt_pkg::OFS_STATUS, 32'h2, 32'h2);
    wr(syt_pkg::OFS_CONTROL, 32'h1);
    ticks(120);
    chk("wd restart", 32'h1, wdr_seen);
    wr(syt_pkg::OFS_WATCHDOG, 32'h00000001);
    ovf_low = 0;
    ticks(16);
    rd("wd flag2", syt_pkg::OFS_STATUS, 32'h2, 32'h2);
    chk("no reset", 32'h1, wdr_seen);
    chk("no ovf", 32'h0, ovf_low);
    $display("test watchdog done");
    conclude();
  end
endmodule // syt_timer_regs_test
`default_nettype wire
